// ===== rtl/via_cfg.svh
// Constants of the vectored interrupt acceptance block: offsets, fields,
// reset values and timing counts. Assumes an 8-bit register port.
`ifndef VIA_CFG_SVH
`define VIA_CFG_SVH

// ==========================================================================
// Register port
`define VIA_ADDR_W        8
`define VIA_DATA_W        8
`define VIA_PSW_OFS       8'h00
`define VIA_NMI_OFS       8'h01
`define VIA_LAST_OFS      8'h1c
`define VIA_ICR_REQ_BIT   0
`define VIA_ICR_EN_BIT    1
`define VIA_ICR_LV_LSB    6
`define VIA_PSW_IM_LSB    4
`define VIA_PSW_MIE_BIT   6
`define VIA_PSW_RST       8'h00
`define VIA_ICR_RST       4'h0

// ==========================================================================
// Vectors
`define VIA_PC_W          20
`define VIA_VEC_BASE      20'h04000
`define VIA_NMI_VEC       5'h01
`define VIA_FIRST_MASK    2
`define VIA_LAST_MASK     28
`define VIA_LAST_EXT      7
`define VIA_IMPL_MASK     29'h17e7befc
`define VIA_LVL_OFF       2'h3

// ==========================================================================
// Timing
`define VIA_CLK_MHZ       200
`define VIA_MC_CLKS       1
`define VIA_RESP_MAX_MC   12
`define VIA_RET_MAX_MC    11

`endif

// ===== rtl/via_pkg.sv
// Types of the vectored interrupt acceptance block.
// Assumes via_cfg.svh is on the include path.
`include "via_cfg.svh"

package via_pkg;

	// ======================================================================
	// Sequencer states
	typedef enum logic [9:0] {
		VIA_S_RESET_VEC = 10'h001,
		VIA_S_IDLE      = 10'h002,
		VIA_S_PUSH_PC   = 10'h004,
		VIA_S_PUSH_PSW  = 10'h008,
		VIA_S_PUSH_HA   = 10'h010,
		VIA_S_BRANCH    = 10'h020,
		VIA_S_POP_HA    = 10'h040,
		VIA_S_POP_PSW   = 10'h080,
		VIA_S_POP_PC    = 10'h100,
		VIA_S_RESUME    = 10'h200
	} via_state_t;

	// ======================================================================
	// Carriers
	typedef enum logic [1:0] {
		VIA_STK_PC  = 2'h0,
		VIA_STK_PSW = 2'h1,
		VIA_STK_HA  = 2'h2
	} via_stk_kind_t;

	typedef struct packed {
		via_stk_kind_t               kind;
		logic [`VIA_PC_W-1:0]        data;
	} via_stk_word_t;

	typedef struct packed {
		logic                        flag7;
		logic                        global_maskable_enable;
		logic [1:0]                  mask_level;
		logic [3:0]                  flags;
	} via_psw_t;

	typedef struct packed {
		logic [1:0]                  level_field;
		logic                        enable_flag;
		logic                        request_flag;
	} via_icr_t;

	typedef struct packed {
		logic                        wr;
		logic                        rd;
		logic [`VIA_ADDR_W-1:0]      addr;
		logic [`VIA_DATA_W-1:0]      wdata;
	} via_bus_req_t;

endpackage : via_pkg

// ===== rtl/via_arbiter.sv
// Maskable request arbiter: picks the best eligible vector.
// Assumes registered flags at its inputs; purely combinational.
`timescale 1ns/100ps
`include "via_cfg.svh"

module via_arbiter
	import via_pkg::*;
(
	input  wire logic [28:0]       pend_i,
	input  wire logic [28:0]       en_i,
	input  wire logic [28:0][1:0]  lvl_i,
	input  wire logic              mie_i,
	input  wire logic [1:0]        im_i,
	output logic                   win_o,
	output logic [4:0]             win_vec_o,
	output logic [1:0]             win_lvl_o
);

	// ======================================================================
	// Scan from the top so ties fall to the lowest vector
	always_comb begin
		win_o     = 1'b0;
		win_vec_o = 5'h00;
		win_lvl_o = `VIA_LVL_OFF;
		for (int v = `VIA_LAST_MASK; v >= `VIA_FIRST_MASK; v--) begin
			if (pend_i[v] && en_i[v] && mie_i
			    && (lvl_i[v] != `VIA_LVL_OFF)
			    && (lvl_i[v] < im_i)
			    && (lvl_i[v] <= win_lvl_o)) begin
				win_o     = 1'b1;
				win_vec_o = 5'(v);
				win_lvl_o = lvl_i[v];
			end
		end
	end

endmodule : via_arbiter

// ===== rtl/via_top.sv
// Vectored interrupt acceptance: control registers, acceptance, stacking
// sequence, vector fetch and return. Assumes the CPU core owns the stack
// pointer, takes push words on push_o and answers pop_o in the same cycle.
`timescale 1ns/100ps
`include "via_cfg.svh"

module via_top
	import via_pkg::*;
(
	input  wire logic                   core_clk_i,
	input  wire logic                   rst_i,
	input  wire via_bus_req_t           bus_i,
	output logic [`VIA_DATA_W-1:0]      rdata_o,
	input  wire logic [5:0]             ext_irq_i,
	input  wire logic [15:0]            periph_irq_i,
	input  wire logic                   err_det_i,
	input  wire logic                   pi_irq_i,
	input  wire logic [`VIA_PC_W-1:0]   pc_i,
	input  wire logic [15:0]            ha_i,
	input  wire logic                   rti_i,
	input  wire logic [`VIA_PC_W-1:0]   pop_data_i,
	output logic                        push_o,
	output via_stk_word_t               push_word_o,
	output logic                        pop_o,
	output logic                        branch_o,
	output logic [`VIA_PC_W-1:0]        vec_addr_o,
	output logic                        resume_o,
	output logic [`VIA_PC_W-1:0]        resume_addr_o,
	output via_psw_t                    psw_o
);

	localparam logic [28:0] IMPL     = `VIA_IMPL_MASK;
	localparam int          RESP_MAX = `VIA_RESP_MAX_MC * `VIA_MC_CLKS;
	localparam int          RET_MAX  = `VIA_RET_MAX_MC * `VIA_MC_CLKS;

	via_state_t              state_q;
	via_state_t              state_d;
	via_icr_t [28:0]         icr_q;
	via_psw_t                psw_q;
	via_psw_t                saved_psw_q;
	logic [15:0]             ha_save_q;
	logic [`VIA_PC_W-1:0]    vec_addr_q;
	logic [`VIA_PC_W-1:0]    resume_addr_q;
	via_stk_word_t           push_word_q;
	logic [`VIA_DATA_W-1:0]  rdata_q;
	logic [28:0]             src_hit;
	logic [28:0]             pend;
	logic [28:0]             ena;
	logic [28:0][1:0]        lvl;
	logic                    arb_win;
	logic [4:0]              arb_vec;
	logic [1:0]              arb_lvl;
	logic                    accept_w;
	logic                    acc_nmi;
	logic [4:0]              acc_vec;
	logic                    rti_take;

	// ======================================================================
	// Source map: pins on vectors 2..7, peripherals on the used slots above
	always_comb begin
		int k;
		k       = 0;
		src_hit = '0;
		for (int v = `VIA_FIRST_MASK; v <= `VIA_LAST_MASK; v++) begin
			if (IMPL[v]) begin
				if (v <= `VIA_LAST_EXT) begin
					src_hit[v] = ext_irq_i[v-2];
				end else begin
					src_hit[v] = periph_irq_i[k];
					k++;
				end
			end
		end
		src_hit[`VIA_NMI_VEC] = err_det_i | pi_irq_i;
	end

	// ======================================================================
	// Per-source control registers; reserved slots stay zero
	genvar gv;
	generate
		for (gv = 0; gv <= `VIA_LAST_MASK; gv++) begin : g_icr
			if ((gv == 1) || IMPL[gv]) begin : g_used
				logic wr_hit;
				logic acc_hit;
				assign wr_hit  = bus_i.wr && (bus_i.addr == 8'(gv));
				assign acc_hit = accept_w && (acc_vec == 5'(gv));
				// Source set beats both a write and the acceptance clear
				always_ff @(posedge core_clk_i) begin
					if (rst_i) begin
						icr_q[gv].request_flag <= 1'b0;
					end else if (src_hit[gv]) begin
						icr_q[gv].request_flag <= 1'b1;
					end else if (wr_hit) begin
						icr_q[gv].request_flag <= bus_i.wdata[`VIA_ICR_REQ_BIT];
					end else if (acc_hit) begin
						icr_q[gv].request_flag <= 1'b0;
					end
				end
				// NMI slot has no enable or level; acceptance never touches them
				always_ff @(posedge core_clk_i) begin
					if (rst_i || (gv == 1)) begin
						icr_q[gv].enable_flag <= 1'b0;
						icr_q[gv].level_field <= 2'h0;
					end else if (wr_hit) begin
						icr_q[gv].enable_flag <= bus_i.wdata[`VIA_ICR_EN_BIT];
						icr_q[gv].level_field <= bus_i.wdata[`VIA_ICR_LV_LSB +: 2];
					end
				end
			end else begin : g_rsvd
				assign icr_q[gv] = `VIA_ICR_RST;
			end
			assign pend[gv] = icr_q[gv].request_flag;
			assign ena[gv]  = icr_q[gv].enable_flag;
			assign lvl[gv]  = icr_q[gv].level_field;
		end
	endgenerate

	// ======================================================================
	// Arbitration and acceptance
	via_arbiter u_arb (
		.pend_i    (pend),
		.en_i      (ena),
		.lvl_i     (lvl),
		.mie_i     (psw_q.global_maskable_enable),
		.im_i      (psw_q.mask_level),
		.win_o     (arb_win),
		.win_vec_o (arb_vec),
		.win_lvl_o (arb_lvl)
	);

	// Return is taken first so a pending request cannot swallow it
	assign rti_take = (state_q == VIA_S_IDLE) && rti_i;
	assign acc_nmi  = pend[`VIA_NMI_VEC];
	assign accept_w = (state_q == VIA_S_IDLE) && !rti_i && (acc_nmi || arb_win);
	assign acc_vec  = acc_nmi ? `VIA_NMI_VEC : arb_vec;

	// ======================================================================
	// Sequencer: accept, three pushes, branch; or three pops, resume
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			VIA_S_RESET_VEC: state_d = VIA_S_IDLE;
			VIA_S_IDLE: begin
				if (rti_take) begin
					state_d = VIA_S_POP_HA;
				end else if (accept_w) begin
					state_d = VIA_S_PUSH_PC;
				end
			end
			VIA_S_PUSH_PC:   state_d = VIA_S_PUSH_PSW;
			VIA_S_PUSH_PSW:  state_d = VIA_S_PUSH_HA;
			VIA_S_PUSH_HA:   state_d = VIA_S_BRANCH;
			VIA_S_BRANCH:    state_d = VIA_S_IDLE;
			VIA_S_POP_HA:    state_d = VIA_S_POP_PSW;
			VIA_S_POP_PSW:   state_d = VIA_S_POP_PC;
			VIA_S_POP_PC:    state_d = VIA_S_RESUME;
			VIA_S_RESUME:    state_d = VIA_S_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			state_q <= VIA_S_RESET_VEC;
		end else begin
			state_q <= state_d;
		end
	end

	// ======================================================================
	// Status word: reset clears all, acceptance moves mask, return restores
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			psw_q <= `VIA_PSW_RST;
		end else if (accept_w) begin
			psw_q.mask_level <= acc_nmi ? 2'h0 : arb_lvl;
		end else if (state_q == VIA_S_POP_PSW) begin
			psw_q <= pop_data_i[7:0];
		end else if (bus_i.wr && (bus_i.addr == `VIA_PSW_OFS)) begin
			psw_q <= bus_i.wdata;
		end
	end

	// Old status word and context are caught before the mask moves
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			saved_psw_q <= `VIA_PSW_RST;
			ha_save_q   <= 16'h0000;
		end else if (accept_w) begin
			saved_psw_q <= psw_q;
			ha_save_q   <= ha_i;
		end
	end

	// ======================================================================
	// Push word stream and vector address
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			push_word_q <= '0;
		end else if (accept_w) begin
			push_word_q <= '{kind: VIA_STK_PC, data: pc_i};
		end else if (state_q == VIA_S_PUSH_PC) begin
			push_word_q <= '{kind: VIA_STK_PSW, data: {12'h000, saved_psw_q}};
		end else if (state_q == VIA_S_PUSH_PSW) begin
			push_word_q <= '{kind: VIA_STK_HA, data: {4'h0, ha_save_q}};
		end
	end

	// Table entry is base plus four bytes per vector number
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			vec_addr_q <= `VIA_VEC_BASE;
		end else if (accept_w) begin
			vec_addr_q <= `VIA_VEC_BASE + {13'h0000, acc_vec, 2'b00};
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			resume_addr_q <= '0;
		end else if (state_q == VIA_S_POP_PC) begin
			resume_addr_q <= pop_data_i;
		end
	end

	// ======================================================================
	// Register reads: data the cycle after the strobe, zero otherwise
	always_ff @(posedge core_clk_i) begin
		if (rst_i || !bus_i.rd) begin
			rdata_q <= 8'h00;
		end else if (bus_i.addr == `VIA_PSW_OFS) begin
			rdata_q <= psw_q;
		end else if (bus_i.addr <= `VIA_LAST_OFS) begin
			rdata_q <= {icr_q[bus_i.addr[4:0]].level_field, 4'h0,
			            icr_q[bus_i.addr[4:0]].enable_flag,
			            icr_q[bus_i.addr[4:0]].request_flag};
		end else begin
			rdata_q <= 8'h00;
		end
	end

	// ======================================================================
	// Outputs
	assign rdata_o       = rdata_q;
	assign push_o        = (state_q == VIA_S_PUSH_PC) || (state_q == VIA_S_PUSH_PSW)
	                       || (state_q == VIA_S_PUSH_HA);
	assign pop_o         = (state_q == VIA_S_POP_HA) || (state_q == VIA_S_POP_PSW)
	                       || (state_q == VIA_S_POP_PC);
	assign branch_o      = (state_q == VIA_S_BRANCH) || (state_q == VIA_S_RESET_VEC);
	assign resume_o      = (state_q == VIA_S_RESUME);
	assign push_word_o   = push_word_q;
	assign vec_addr_o    = vec_addr_q;
	assign resume_addr_o = resume_addr_q;
	assign psw_o         = psw_q;

	// ======================================================================
	// Checks
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	sequence s_push;
		push_o && (push_word_o.kind == VIA_STK_PC)
		##1 push_o && (push_word_o.kind == VIA_STK_PSW)
		##1 push_o && (push_word_o.kind == VIA_STK_HA)
		##1 branch_o;
	endsequence

	sequence s_pop;
		pop_o ##1 pop_o ##1 pop_o ##1 resume_o;
	endsequence

	chk_vec_fetch_addr: assert property (
		accept_w |-> ##4 branch_o && (vec_addr_o == `VIA_VEC_BASE + {13'h0000, $past(acc_vec, 4), 2'b00}))
		else $error("vector address does not match accepted source");

	chk_push_order: assert property (accept_w |=> s_push)
		else $error("context push order broken");

	chk_return_pops: assert property (rti_take |=> s_pop)
		else $error("return sequence broken");

	chk_resp_bound: assert property (accept_w |-> ##[1:RESP_MAX] branch_o)
		else $error("response too slow");

	chk_ret_bound: assert property (rti_take |-> ##[1:RET_MAX] resume_o)
		else $error("return too slow");

	chk_req_cleared: assert property (
		accept_w && !src_hit[acc_vec] && !bus_i.wr |=> !pend[$past(acc_vec)])
		else $error("request flag not cleared on acceptance");

	chk_nmi_uncond: assert property (
		(state_q == VIA_S_IDLE) && !rti_i && pend[1] |-> accept_w && (acc_vec == `VIA_NMI_VEC))
		else $error("pending NMI not accepted");

	chk_mie_gate: assert property (
		accept_w && !acc_nmi |-> psw_q.global_maskable_enable)
		else $error("maskable accepted with global enable clear");

	chk_level_mask: assert property (
		accept_w && !acc_nmi |-> (lvl[acc_vec] < psw_q.mask_level) && ena[acc_vec])
		else $error("maskable accepted without outranking mask level");

	chk_lvl3_off: assert property (accept_w && !acc_nmi |-> lvl[acc_vec] != `VIA_LVL_OFF)
		else $error("level three vector accepted");

	chk_nmi_mask_zero: assert property (accept_w && acc_nmi |=> psw_q.mask_level == 2'h0)
		else $error("NMI did not zero mask level");

	chk_mask_copy: assert property (accept_w && !acc_nmi |=> psw_q.mask_level == $past(lvl[acc_vec]))
		else $error("mask level not copied from level field");

	chk_psw_restore: assert property (
		(state_q == VIA_S_POP_PSW) |=> psw_q == $past(pop_data_i[7:0]))
		else $error("status word not restored on return");

	chk_pend_hold: assert property (
		pend[5] && !bus_i.wr && !(accept_w && acc_vec == 5'h05) |=> pend[5])
		else $error("pending request lost");

endmodule : via_top

// ===== testbench/via_core_model.sv
// CPU core stand-in: keeps the stack that acceptance pushes onto and
// hands the words back on return. Assumes one clock, pushes and pops in order.
`timescale 1ns/100ps
`include "via_cfg.svh"

module via_core_model
	import via_pkg::*;
(
	input  wire logic                 core_clk_i,
	input  wire logic                 rst_i,
	input  wire logic                 push_o,
	input  wire via_stk_word_t        push_word_o,
	input  wire logic                 pop_o,
	output logic [`VIA_PC_W-1:0]      pop_data_o
);
	// ======================================================================
	// Stack
	logic [`VIA_PC_W-1:0] stk_q [0:7];
	logic [2:0]           sp_q;

	// Last in, first out: pops see HA, PROCESSOR_STATUS_WORD, then PC
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			sp_q <= 3'h0;
		end else if (push_o) begin
			stk_q[sp_q] <= push_word_o.data;
			sp_q        <= sp_q + 3'h1;
		end else if (pop_o) begin
			sp_q <= sp_q - 3'h1;
		end
	end

	// Outside a pop the bus shows the inverse, so stale data cannot pass
	assign pop_data_o = pop_o ? stk_q[sp_q - 3'h1] : ~stk_q[sp_q];
endmodule : via_core_model

// ===== testbench/tb_vectored_interrupt_acceptance.sv
// Bench for via_top: register port tasks, source pulses, accept and return.
// Assumes the core model answers pops in the same cycle.
`timescale 1ns/100ps
`include "via_cfg.svh"

module tb_vectored_interrupt_acceptance
	import via_pkg::*;
();
	// ======================================================================
	// Signals
	logic                 core_clk_i;
	logic                 rst_i;
	via_bus_req_t         bus_i;
	logic [7:0]           rdata_o;
	logic [5:0]           ext_irq_i;
	logic [15:0]          periph_irq_i;
	logic                 err_det_i;
	logic                 pi_irq_i;
	logic [19:0]          pc_i;
	logic [15:0]          ha_i;
	logic                 rti_i;
	logic [19:0]          pop_data_i;
	logic                 push_o;
	via_stk_word_t        push_word_o;
	logic                 pop_o;
	logic                 branch_o;
	logic [19:0]          vec_addr_o;
	logic                 resume_o;
	logic [19:0]          resume_addr_o;
	via_psw_t             psw_o;
	int                   n_mismatch;
	int                   total_checks;

	via_top u_via_top (.core_clk_i(core_clk_i), .rst_i(rst_i), .bus_i(bus_i), .rdata_o(rdata_o),
		.ext_irq_i(ext_irq_i), .periph_irq_i(periph_irq_i), .err_det_i(err_det_i), .pi_irq_i(pi_irq_i),
		.pc_i(pc_i), .ha_i(ha_i), .rti_i(rti_i), .pop_data_i(pop_data_i), .push_o(push_o),
		.push_word_o(push_word_o), .pop_o(pop_o), .branch_o(branch_o), .vec_addr_o(vec_addr_o),
		.resume_o(resume_o), .resume_addr_o(resume_addr_o), .psw_o(psw_o));

	via_core_model u_via_core_model (.core_clk_i(core_clk_i), .rst_i(rst_i), .push_o(push_o),
		.push_word_o(push_word_o), .pop_o(pop_o), .pop_data_o(pop_data_i));

	// 200 MHz
	initial begin
		core_clk_i = 1'b0;
		forever #2.5 core_clk_i = ~core_clk_i;
	end

	// ======================================================================
	// Shared tasks
	task automatic chk(input bit ok, input string msg);
		total_checks++;
		if (!ok) begin
			n_mismatch++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		bus_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge core_clk_i);
		bus_i <= '0;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string msg);
		@(posedge core_clk_i);
		bus_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge core_clk_i);
		bus_i <= '0;
		#1;
		chk(rdata_o === exp, msg);
	endtask : rd_chk

	// One-cycle pulse on {pi, err, periph, ext}
	task automatic pulse(input logic [23:0] m);
		@(posedge core_clk_i);
		{pi_irq_i, err_det_i, periph_irq_i, ext_irq_i} <= m;
		@(posedge core_clk_i);
		{pi_irq_i, err_det_i, periph_irq_i, ext_irq_i} <= '0;
	endtask : pulse

	// Collects the pushed words up to the branch, bounded at 11 cycles
	task automatic take(input logic [19:0] vec, input logic [7:0] old_psw, input logic [7:0] new_psw);
		via_stk_word_t w [3];
		int            k;
		int            n;
		k = 0;
		n = 0;
		while (branch_o !== 1'b1 && n < 11) begin
			@(posedge core_clk_i);
			#1;
			if (push_o === 1'b1 && k < 3) begin
				w[k] = push_word_o;
				k++;
			end
			n++;
		end
		chk(branch_o === 1'b1, "no branch in time");
		chk(vec_addr_o === vec, "vector address");
		chk(k == 3 && w[0].kind === VIA_STK_PC && w[0].data === pc_i, "pushed pc");
		chk(w[1].kind === VIA_STK_PSW && w[1].data[7:0] === old_psw, "pushed status word");
		chk(w[2].kind === VIA_STK_HA && w[2].data[15:0] === ha_i, "pushed handy data");
		chk(psw_o === new_psw, "mask level after accept");
	endtask : take

	task automatic ret(input logic [7:0] exp_psw);
		int n;
		@(posedge core_clk_i);
		rti_i <= 1'b1;
		@(posedge core_clk_i);
		rti_i <= 1'b0;
		n = 0;
		while (resume_o !== 1'b1 && n < 11) begin
			@(posedge core_clk_i);
			#1;
			n++;
		end
		chk(resume_o === 1'b1, "no resume in time");
		chk(resume_addr_o === pc_i, "resume address");
		chk(psw_o === exp_psw, "restored status word");
	endtask : ret

	// Nothing may be accepted for 16 cycles
	task automatic quiet(input string msg);
		bit seen;
		seen = 1'b0;
		repeat (16) begin
			@(posedge core_clk_i);
			#1;
			if (push_o !== 1'b0)
				seen = 1'b1;
		end
		chk(!seen, msg);
	endtask : quiet

	// ======================================================================
	// Scenarios
	task automatic t_regs();
		rd_chk(8'h00, 8'h00, "status word reset");
		rd_chk(8'h05, 8'h00, "control reset");
		wr(8'h05, 8'hc2);
		rd_chk(8'h05, 8'hc2, "control fields");
		wr(8'h08, 8'hff);
		rd_chk(8'h08, 8'h00, "reserved vector");
		rd_chk(8'h1d, 8'h00, "unmapped address");
		wr(8'h05, 8'h00);
		$display("test regs done");
	endtask : t_regs

	// Both causes at the highest mask level; second pass with global enable clear
	task automatic t_nmi();
		for (int i = 0; i < 2; i++) begin
			pc_i <= 20'h12340 + 20'(i);
			ha_i <= 16'hbee0 + 16'(i);
			wr(8'h00, i == 0 ? 8'h70 : 8'h30);
			pulse(i == 0 ? 24'h400000 : 24'h800000);
			take(20'h04004, i == 0 ? 8'h70 : 8'h30, i == 0 ? 8'h40 : 8'h00);
			ret(i == 0 ? 8'h70 : 8'h30);
		end
		$display("test nmi done");
	endtask : t_nmi

	// Two pins, same level, together: lower vector first, other held
	task automatic t_tie();
		pc_i <= 20'h0a5a5;
		wr(8'h00, 8'h60);
		wr(8'h02, 8'h42);
		wr(8'h03, 8'h42);
		pulse(24'h000003);
		take(20'h04008, 8'h60, 8'h50);
		rd_chk(8'h02, 8'h42, "accepted flag cleared, enable kept");
		rd_chk(8'h03, 8'h43, "loser still pending");
		quiet("equal level taken");
		ret(8'h60);
		take(20'h0400c, 8'h60, 8'h50);
		ret(8'h60);
		$display("test tie done");
	endtask : t_tie

	task automatic t_mie();
		wr(8'h00, 8'h20);
		wr(8'h09, 8'h02);
		pulse(24'h000040);
		quiet("taken with global enable clear");
		rd_chk(8'h09, 8'h03, "held while masked");
		wr(8'h09, 8'h02);
		rd_chk(8'h09, 8'h02, "software clear");
		wr(8'h00, 8'h60);
		quiet("cleared request taken");
		pulse(24'h000040);
		take(20'h04024, 8'h60, 8'h40);
		ret(8'h60);
		$display("test mie done");
	endtask : t_mie

	// Level three blocks even with enable and request set
	task automatic t_lvl3();
		wr(8'h1c, 8'hc2);
		pulse(24'h200000);
		quiet("level three taken");
		rd_chk(8'h1c, 8'hc3, "request kept");
		wr(8'h1c, 8'h43);
		take(20'h04070, 8'h60, 8'h50);
		ret(8'h60);
		$display("test lvl3 done");
	endtask : t_lvl3

	// Higher priority beats a lower vector; the loser waits for the mask
	task automatic t_prio();
		wr(8'h00, 8'h70);
		wr(8'h04, 8'h82);
		wr(8'h05, 8'h42);
		pulse(24'h00000c);
		take(20'h04014, 8'h70, 8'h50);
		quiet("lower level taken over mask");
		ret(8'h70);
		take(20'h04010, 8'h70, 8'h60);
		ret(8'h70);
		$display("test prio done");
	endtask : t_prio

	// Reset in mid-acceptance: vector again, status word and controls cleared
	task automatic t_rst();
		wr(8'h00, 8'h0f);
		pulse(24'h000040);
		wr(8'h01, 8'h01);
		@(posedge core_clk_i);
		rst_i <= 1'b1;
		#1;
		chk(push_o === 1'b1, "software nmi request taken");
		repeat (2) @(posedge core_clk_i);
		rst_i <= 1'b0;
		#1;
		chk(branch_o === 1'b1 && vec_addr_o === 20'h04000 && push_o === 1'b0, "mid-run reset vector");
		chk(psw_o === 8'h00, "status word cleared mid-run");
		rd_chk(8'h09, 8'h00, "control cleared by reset");
		rd_chk(8'h01, 8'h00, "nmi request cleared by reset");
		$display("test rst done");
	endtask : t_rst

	// ======================================================================
	// Verdict
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : results

	// Tests take about 240 cycles; twenty times that is a hang
	initial begin
		#25000;
		n_mismatch++;
		$display("mismatch at %0t: watchdog expired", $time);
		results();
	end

	initial begin
		n_mismatch = 0;
		total_checks = 0;
		rst_i = 1'b1;
		bus_i = '0;
		{pi_irq_i, err_det_i, periph_irq_i, ext_irq_i} = '0;
		rti_i = 1'b0;
		pc_i = 20'h00000;
		ha_i = 16'h0000;
		repeat (5) @(posedge core_clk_i);
		rst_i <= 1'b0;
		// First cycle after release still shows the reset vector
		#1;
		chk(branch_o === 1'b1 && vec_addr_o === 20'h04000, "reset vector");
		chk(psw_o === 8'h00, "status word cleared");
		t_regs();
		t_nmi();
		t_tie();
		t_mie();
		t_lvl3();
		t_prio();
		t_rst();
		results();
	end
endmodule : tb_vectored_interrupt_acceptance
